// File: clock_select_pkg.sv
package clock_select_pkg;

  // ********************************
  // bus carrier
  // ********************************
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] core;
    logic [31:0] fast_bus;
    logic [31:0] periph_a;
    logic [31:0] periph_b;
    logic [31:0] periph_a_div;
  } gate_bus_t;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [9:0] OFF_MAIN_CTRL = 10'h000;
  localparam logic [9:0] OFF_CPU_SEL = 10'h004;
  localparam logic [9:0] OFF_FAST_SEL = 10'h008;
  localparam logic [9:0] OFF_PA_SEL = 10'h00c;
  localparam logic [9:0] OFF_PB_SEL = 10'h010;
  localparam logic [9:0] OFF_CORE_GATE = 10'h020;
  localparam logic [9:0] OFF_FAST_GATE = 10'h024;
  localparam logic [9:0] OFF_PA_GATE = 10'h028;
  localparam logic [9:0] OFF_PB_GATE = 10'h02c;
  localparam logic [9:0] OFF_PA_DIV_GATE = 10'h040;
  localparam logic [9:0] OFF_CFD_CTRL = 10'h054;
  localparam logic [9:0] OFF_LOCK_KEY = 10'h058;
  localparam logic [9:0] OFF_IRQ_SET = 10'h0c0;
  localparam logic [9:0] OFF_IRQ_CLR_EN = 10'h0c4;
  localparam logic [9:0] OFF_IRQ_VIEW = 10'h0c8;
  localparam logic [9:0] OFF_IRQ_PEND = 10'h0cc;
  localparam logic [9:0] OFF_IRQ_ACK = 10'h0d0;
  localparam logic [9:0] OFF_STATE = 10'h0d4;
  localparam logic [9:0] OFF_PERIPH_POWER_CONTROL = 10'h160;
  localparam logic [9:0] OFF_RST_SRC = 10'h180;
  localparam logic [9:0] OFF_WAKE_SRC = 10'h184;
  localparam logic [9:0] OFF_WAKE_EN = 10'h188;
  localparam logic [9:0] OFF_CONFIG = 10'h3f8;
  localparam logic [9:0] OFF_VERSION = 10'h3fc;

  // ********************************
  // fields
  // ********************************
  localparam int DIV_EN_BIT = 7;
  localparam int RATIO_W = 3;
  localparam int CFD_EN_BIT = 0;
  localparam int CFD_SFV_BIT = 31;
  localparam int KEY_LSB = 24;
  localparam logic [7:0] UNLOCK_KEY = 8'haa;
  localparam int IRQ_CFD_BIT = 0;
  localparam int IRQ_READY_BIT = 5;
  localparam int IRQ_AE_BIT = 31;
  localparam logic [31:0] IRQ_IMPL = 32'h80000021;
  localparam logic [2:0] SRC_SYS_RC = 3'h0;
  localparam logic [2:0] SRC_CRYSTAL0 = 3'h1;
  localparam logic [2:0] SRC_FLL = 3'h2;
  localparam logic [2:0] SRC_FAST_RC = 3'h3;

  // ********************************
  // reset values
  // ********************************
  localparam logic [31:0] RST_SEL = 32'h00000000;
  localparam logic [31:0] RST_CORE_GATE = 32'h00010001;
  localparam logic [31:0] RST_FAST_GATE = 32'h0000007f;
  localparam logic [31:0] RST_PA_GATE = 32'h0fffffff;
  localparam logic [31:0] RST_PB_GATE = 32'h0000000f;
  localparam logic [31:0] RST_PA_DIV_GATE = 32'h0000007f;
  localparam logic [31:0] RST_PERIPH_POWER_CONTROL = 32'h000001fa;
  localparam logic [31:0] CONFIG_VALUE = 32'h00000043;
  // arbitrary value
  localparam logic [31:0] VERSION_VALUE = 32'h00000100;

  // divisor 2^(ratio+1)
  function automatic logic [8:0] divisor(input logic [2:0] ratio);
    divisor = 9'h001 << ({1'b0, ratio} + 4'h1);
  endfunction

endpackage

// File: pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level
);
  logic meta;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= pin;
      level <= meta;
    end
  end
endmodule // pin_sync

// File: clk_prescaler.sv
`timescale 1ns/1ps
module clk_prescaler (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic divide_enable,
  input wire logic [2:0] ratio,
  output logic wrap,
  output logic tick
);
  logic [7:0] cnt;
  wire [7:0] limit = 8'(clock_select_pkg::divisor(ratio) - 9'h001);

  assign wrap = divide_enable ? (cnt == limit) : 1'b1;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt <= wrap ? 8'h00 : cnt + 8'h01;
      tick <= wrap;
    end
  end
endmodule // clk_prescaler

// File: clock_select.sv
`timescale 1ns/1ps
module clock_select (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire clock_select_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic clock_failure,
  input wire logic [31:0] reset_cause,
  input wire logic [31:0] wake_cause,
  output logic [2:0] main_source,
  output logic cpu_tick,
  output logic fast_bus_tick,
  output logic [7:0] periph_a_select,
  output logic [7:0] periph_b_select,
  output clock_select_pkg::gate_bus_t gates,
  output logic [31:0] periph_power,
  output logic [31:0] wake_enable,
  output logic irq
);

  // ********************************
  // reset release
  // ********************************
  logic rst_meta_b;
  logic rst_q_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_q_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_q_b <= rst_meta_b;
    end
  end

  // ********************************
  // decode
  // ********************************
  typedef enum logic {LOCK_CLOSED, LOCK_OPEN} lock_state_t;

  function automatic logic is_protected(input logic [9:0] a);
    is_protected = (a == clock_select_pkg::OFF_MAIN_CTRL) ||
                   (a == clock_select_pkg::OFF_CPU_SEL) ||
                   (a == clock_select_pkg::OFF_PA_SEL) ||
                   (a == clock_select_pkg::OFF_PB_SEL) ||
                   (a == clock_select_pkg::OFF_CORE_GATE) ||
                   (a == clock_select_pkg::OFF_FAST_GATE) ||
                   (a == clock_select_pkg::OFF_PA_GATE) ||
                   (a == clock_select_pkg::OFF_PB_GATE) ||
                   (a == clock_select_pkg::OFF_PA_DIV_GATE) ||
                   (a == clock_select_pkg::OFF_CFD_CTRL);
  endfunction

  function automatic logic rising(input logic prev, input logic now);
    rising = now && !prev;
  endfunction

  lock_state_t lock_state;
  logic [9:0] unlock_addr;
  logic [31:0] cfd_ctrl;
  logic [31:0] wd;

  assign wd = bus.wdata;
  wire key_ok = bus.wr && (bus.addr == clock_select_pkg::OFF_LOCK_KEY) &&
                (wd[31:clock_select_pkg::KEY_LSB] == clock_select_pkg::UNLOCK_KEY);
  wire granted = (lock_state == LOCK_OPEN) && (unlock_addr == bus.addr);
  wire prot_wr = bus.wr && is_protected(bus.addr);
  wire wr_ok = prot_wr && granted;
  wire wr_denied = prot_wr && !granted;
  wire wr_main = wr_ok && (bus.addr == clock_select_pkg::OFF_MAIN_CTRL);
  wire wr_cpu = wr_ok && (bus.addr == clock_select_pkg::OFF_CPU_SEL);
  wire sfv = cfd_ctrl[clock_select_pkg::CFD_SFV_BIT];
  wire wr_cfd = wr_ok && !sfv && (bus.addr == clock_select_pkg::OFF_CFD_CTRL);
  wire wr_ier = bus.wr && (bus.addr == clock_select_pkg::OFF_IRQ_SET);
  wire wr_idr = bus.wr && (bus.addr == clock_select_pkg::OFF_IRQ_CLR_EN);
  wire wr_icr = bus.wr && (bus.addr == clock_select_pkg::OFF_IRQ_ACK);
  wire wr_async_wake_enable = bus.wr && (bus.addr == clock_select_pkg::OFF_WAKE_EN);
  wire wr_periph_power_control = bus.wr && (bus.addr == clock_select_pkg::OFF_PERIPH_POWER_CONTROL);

  // ********************************
  // unlock sequence
  // ********************************
  lock_state_t next_lock_state;

  always_comb begin
    next_lock_state = lock_state;
    unique case (lock_state)
      LOCK_CLOSED: begin
        if (key_ok) begin
          next_lock_state = LOCK_OPEN;
        end
      end
      LOCK_OPEN: begin
        if (bus.wr && !key_ok) begin
          next_lock_state = LOCK_CLOSED;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      lock_state <= LOCK_CLOSED;
      unlock_addr <= 10'h000;
    end else begin
      lock_state <= next_lock_state;
      if (key_ok) begin
        unlock_addr <= wd[9:0];
      end
    end
  end

  // ********************************
  // main source and failure
  // ********************************
  logic fail_sync;
  logic cfd_flag;

  pin_sync u_fail_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_q_b),
    .pin(clock_failure),
    .level(fail_sync)
  );

  wire cfd_en = cfd_ctrl[clock_select_pkg::CFD_EN_BIT];
  wire fail_force = fail_sync && cfd_en && (main_source != clock_select_pkg::SRC_SYS_RC);

  always_ff @(posedge sys_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      main_source <= clock_select_pkg::SRC_SYS_RC;
      cfd_flag <= 1'b0;
    end else if (fail_force) begin
      main_source <= clock_select_pkg::SRC_SYS_RC;
      cfd_flag <= 1'b1;
    end else if (wr_main) begin
      main_source <= wd[2:0];
      cfd_flag <= 1'b0;
    end
  end

  // ********************************
  // cpu divider
  // ********************************
  logic [7:0] cpu_shadow;
  logic [7:0] active_sel;
  logic pending;
  logic div_wrap;

  wire clock_ready = !pending;
  wire apply = pending && !wr_cpu && (div_wrap || !active_sel[clock_select_pkg::DIV_EN_BIT]);

  clk_prescaler u_cpu_div (
    .sys_clk(sys_clk),
    .rst_b(rst_q_b),
    .divide_enable(active_sel[clock_select_pkg::DIV_EN_BIT]),
    .ratio(active_sel[2:0]),
    .wrap(div_wrap),
    .tick(cpu_tick)
  );

  assign fast_bus_tick = cpu_tick;

  always_ff @(posedge sys_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      cpu_shadow <= clock_select_pkg::RST_SEL[7:0];
      active_sel <= clock_select_pkg::RST_SEL[7:0];
      pending <= 1'b0;
    end else if (wr_cpu) begin
      cpu_shadow <= {wd[7], 4'h0, wd[2:0]};
      pending <= 1'b1;
    end else if (apply) begin
      active_sel <= cpu_shadow;
      pending <= 1'b0;
    end
  end

  // ********************************
  // other registers
  // ********************************
  always_ff @(posedge sys_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      periph_a_select <= clock_select_pkg::RST_SEL[7:0];
      periph_b_select <= clock_select_pkg::RST_SEL[7:0];
      gates.core <= clock_select_pkg::RST_CORE_GATE;
      gates.fast_bus <= clock_select_pkg::RST_FAST_GATE;
      gates.periph_a <= clock_select_pkg::RST_PA_GATE;
      gates.periph_b <= clock_select_pkg::RST_PB_GATE;
      gates.periph_a_div <= clock_select_pkg::RST_PA_DIV_GATE;
      cfd_ctrl <= clock_select_pkg::RST_SEL;
      periph_power <= clock_select_pkg::RST_PERIPH_POWER_CONTROL;
      wake_enable <= clock_select_pkg::RST_SEL;
    end else begin
      if (wr_ok && bus.addr == clock_select_pkg::OFF_PA_SEL) begin
        periph_a_select <= {wd[7], 4'h0, wd[2:0]};
      end
      if (wr_ok && bus.addr == clock_select_pkg::OFF_PB_SEL) begin
        periph_b_select <= {wd[7], 4'h0, wd[2:0]};
      end
      if (wr_ok && bus.addr == clock_select_pkg::OFF_CORE_GATE) begin
        gates.core <= wd & clock_select_pkg::RST_CORE_GATE;
      end
      if (wr_ok && bus.addr == clock_select_pkg::OFF_FAST_GATE) begin
        gates.fast_bus <= wd & clock_select_pkg::RST_FAST_GATE;
      end
      if (wr_ok && bus.addr == clock_select_pkg::OFF_PA_GATE) begin
        gates.periph_a <= wd & clock_select_pkg::RST_PA_GATE;
      end
      if (wr_ok && bus.addr == clock_select_pkg::OFF_PB_GATE) begin
        gates.periph_b <= wd & clock_select_pkg::RST_PB_GATE;
      end
      if (wr_ok && bus.addr == clock_select_pkg::OFF_PA_DIV_GATE) begin
        gates.periph_a_div <= wd & clock_select_pkg::RST_PA_DIV_GATE;
      end
      if (wr_cfd) begin
        cfd_ctrl <= {wd[31], 30'h0, wd[0]};
      end
      if (wr_periph_power_control) begin
        periph_power <= wd;
      end
      if (wr_async_wake_enable) begin
        wake_enable <= wd;
      end
    end
  end

  // ********************************
  // interrupts
  // ********************************
  logic [31:0] irq_pending;
  logic [31:0] irq_mask;
  logic ready_prev;
  logic cfd_prev;

  wire [31:0] events = (32'(rising(ready_prev, clock_ready)) << clock_select_pkg::IRQ_READY_BIT) |
                       (32'(rising(cfd_prev, cfd_flag)) << clock_select_pkg::IRQ_CFD_BIT) |
                       (32'(wr_denied) << clock_select_pkg::IRQ_AE_BIT);
  wire [31:0] ack = wr_icr ? wd : 32'h0;
  wire [31:0] state_flags = (32'(clock_ready) << clock_select_pkg::IRQ_READY_BIT) |
                            (32'(cfd_flag) << clock_select_pkg::IRQ_CFD_BIT);

  assign irq = |(irq_pending & irq_mask);

  always_ff @(posedge sys_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      irq_pending <= 32'h0;
      irq_mask <= 32'h0;
      ready_prev <= 1'b1;
      cfd_prev <= 1'b0;
    end else begin
      irq_pending <= (irq_pending & ~ack) | events;
      irq_mask <= ((irq_mask | (wr_ier ? wd : 32'h0)) & ~(wr_idr ? wd : 32'h0)) &
                  clock_select_pkg::IRQ_IMPL;
      ready_prev <= clock_ready;
      cfd_prev <= cfd_flag;
    end
  end

  // ********************************
  // read back
  // ********************************
  wire [9:0] ra = bus.addr;
  wire [31:0] cpu_view = {24'h0, cpu_shadow};
  wire [31:0] read_mux =
    (ra == clock_select_pkg::OFF_MAIN_CTRL) ? {29'h0, main_source} :
    (ra == clock_select_pkg::OFF_CPU_SEL) ? cpu_view :
    (ra == clock_select_pkg::OFF_FAST_SEL) ? cpu_view :
    (ra == clock_select_pkg::OFF_PA_SEL) ? {24'h0, periph_a_select} :
    (ra == clock_select_pkg::OFF_PB_SEL) ? {24'h0, periph_b_select} :
    (ra == clock_select_pkg::OFF_CORE_GATE) ? gates.core :
    (ra == clock_select_pkg::OFF_FAST_GATE) ? gates.fast_bus :
    (ra == clock_select_pkg::OFF_PA_GATE) ? gates.periph_a :
    (ra == clock_select_pkg::OFF_PB_GATE) ? gates.periph_b :
    (ra == clock_select_pkg::OFF_PA_DIV_GATE) ? gates.periph_a_div :
    (ra == clock_select_pkg::OFF_CFD_CTRL) ? cfd_ctrl :
    (ra == clock_select_pkg::OFF_IRQ_VIEW) ? irq_mask :
    (ra == clock_select_pkg::OFF_IRQ_PEND) ? irq_pending :
    (ra == clock_select_pkg::OFF_STATE) ? state_flags :
    (ra == clock_select_pkg::OFF_PERIPH_POWER_CONTROL) ? periph_power :
    (ra == clock_select_pkg::OFF_RST_SRC) ? reset_cause :
    (ra == clock_select_pkg::OFF_WAKE_SRC) ? wake_cause :
    (ra == clock_select_pkg::OFF_WAKE_EN) ? wake_enable :
    (ra == clock_select_pkg::OFF_CONFIG) ? clock_select_pkg::CONFIG_VALUE :
    (ra == clock_select_pkg::OFF_VERSION) ? clock_select_pkg::VERSION_VALUE :
    32'h0;

  always_ff @(posedge sys_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      rdata <= 32'h0;
    end else begin
      rdata <= bus.rd ? read_mux : 32'h0;
    end
  end

  // ********************************
  // checks
  // ********************************
  logic [8:0] gap;
  logic gap_valid;

  always_ff @(posedge sys_clk or negedge rst_q_b) begin
    if (!rst_q_b) begin
      gap <= 9'h000;
      gap_valid <= 1'b0;
    end else if (apply) begin
      gap <= 9'h000;
      gap_valid <= 1'b0;
    end else if (cpu_tick) begin
      gap <= 9'h001;
      gap_valid <= 1'b1;
    end else begin
      gap <= gap + 9'h001;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_q_b);

  AST_SOURCE_WRITE: assert property (
    wr_main && !fail_force |=> main_source == $past(wd[2:0]))
    else $error("main source did not take written value");

  AST_UNDIVIDED: assert property (
    !active_sel[7] && !apply |=> cpu_tick [*2])
    else $error("undivided cpu tick missing");

  AST_RATIO: assert property (
    cpu_tick && gap_valid && active_sel[7] |->
      gap == clock_select_pkg::divisor(active_sel[2:0]))
    else $error("cpu tick spacing wrong");

  AST_READY_DROP: assert property (
    wr_cpu |=> !clock_ready)
    else $error("clock ready not cleared by cpu write");

  AST_LOCKED_HOLD: assert property (
    bus.wr && bus.addr == clock_select_pkg::OFF_MAIN_CTRL && !granted && !fail_force
      |=> $stable(main_source))
    else $error("locked write changed main source");

  AST_MIRROR: assert property (
    bus.rd && bus.addr == clock_select_pkg::OFF_FAST_SEL |=> rdata == {24'h0, $past(cpu_shadow)})
    else $error("fast bus select does not mirror cpu select");

  AST_ACCESS_ERR: assert property (
    wr_denied |=> irq_pending[clock_select_pkg::IRQ_AE_BIT])
    else $error("access error not flagged");

  AST_READY_IRQ: assert property (
    $rose(clock_ready) |=> irq_pending[clock_select_pkg::IRQ_READY_BIT])
    else $error("clock ready interrupt missing");

  AST_IRQ_GATE: assert property (
    (irq_pending & irq_mask) == 32'h0 |-> !irq)
    else $error("interrupt without unmasked pending bit");

  AST_PENDING_CLEAR: assert property (
    wr_icr && wd[clock_select_pkg::IRQ_AE_BIT] && !events[clock_select_pkg::IRQ_AE_BIT]
      |=> !irq_pending[clock_select_pkg::IRQ_AE_BIT])
    else $error("pending bit not cleared by write of one");

  AST_FAILOVER: assert property (
    fail_force |=> main_source == clock_select_pkg::SRC_SYS_RC && cfd_flag)
    else $error("failure did not switch to system rc");

  COV_UNLOCK_WRITE: cover property (key_ok ##1 wr_main);
  COV_DIVIDE_APPLY: cover property (wr_cpu ##[1:300] $rose(clock_ready));
  COV_FAILOVER: cover property (fail_force);
  COV_DENIED: cover property (wr_denied ##1 irq);

endmodule // clock_select

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  // ********************************
  // signals
  // ********************************
  typedef struct packed {
    logic [9:0] a;
    logic [31:0] e;
  } row_t;
  logic sys_clk;
  logic rst_b;
  clock_select_pkg::bus_req_t bus;
  logic [31:0] rdata;
  logic clock_failure;
  logic [31:0] reset_cause;
  logic [31:0] wake_cause;
  logic [2:0] main_source;
  logic [7:0] pa_sel;
  logic cpu_tick;
  logic fast_bus_tick;
  clock_select_pkg::gate_bus_t gates;
  logic [31:0] v;
  logic irq;
  logic same;
  int num_errors = 0;
  int num_checks = 0;
  int p;
  row_t rows [18];

  clock_select u_clock_select (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bus(bus),
    .rdata(rdata),
    .clock_failure(clock_failure),
    .reset_cause(reset_cause),
    .wake_cause(wake_cause),
    .main_source(main_source),
    .cpu_tick(cpu_tick),
    .fast_bus_tick(fast_bus_tick),
    .periph_a_select(pa_sel),
    .periph_b_select(),
    .gates(gates),
    .periph_power(),
    .wake_enable(),
    .irq(irq)
  );

  // ********************************
  // helpers
  // ********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask

  task automatic pwr(input logic [9:0] a, input logic [31:0] d);
    wr(clock_select_pkg::OFF_LOCK_KEY, {clock_select_pkg::UNLOCK_KEY, 14'h0000, a});
    wr(a, d);
  endtask

  task automatic wait_ready();
    v = '0;
    for (int i = 0; i < 600 && v[5] !== 1'b1; i++) begin
      rd(clock_select_pkg::OFF_STATE, v);
    end
    check({31'h0, v[5]}, 32'h00000001);
  endtask

  task automatic measure(output int n);
    same = 1'b1;
    for (int i = 0; i < 600; i++) begin
      @(posedge sys_clk);
      #1;
      if (cpu_tick === 1'b1) break;
    end
    n = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (fast_bus_tick !== cpu_tick) same = 1'b0;
      if (cpu_tick === 1'b1) break;
    end
    check({31'h0, same}, 32'h00000001);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ********************************
  // clock and watchdog
  // ********************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish();
  end

  // ********************************
  // tests
  // ********************************
  initial begin
    rst_b = 1'b0;
    bus = '0;
    clock_failure = 1'b0;
    reset_cause = 32'h00000005;
    wake_cause = 32'h00000300;
    rows = '{'{10'h000, 32'h00000000}, '{10'h004, 32'h00000000}, '{10'h008, 32'h00000000},
      '{10'h00c, 32'h00000000}, '{10'h010, 32'h00000000}, '{10'h020, 32'h00010001},
      '{10'h024, 32'h0000007f}, '{10'h028, 32'h0fffffff}, '{10'h02c, 32'h0000000f},
      '{10'h040, 32'h0000007f}, '{10'h054, 32'h00000000}, '{10'h058, 32'h00000000},
      '{10'h0c8, 32'h00000000}, '{10'h0cc, 32'h00000000}, '{10'h0d4, 32'h00000020},
      '{10'h160, 32'h000001fa}, '{10'h180, 32'h00000005}, '{10'h014, 32'h00000000}};
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      check(v, rows[i].e);
    end
    check({29'h0, main_source}, 32'h00000000);
    measure(p);
    check(32'(p), 32'h00000001);
    $display("test reset done");

    wr(clock_select_pkg::OFF_IRQ_SET, 32'h80000000);
    wr(clock_select_pkg::OFF_MAIN_CTRL, 32'h00000001);
    check({29'h0, main_source}, 32'h00000000);
    rd(clock_select_pkg::OFF_IRQ_PEND, v);
    check(v, 32'h80000000);
    check({31'h0, irq}, 32'h00000001);
    wr(clock_select_pkg::OFF_IRQ_ACK, 32'h80000000);
    check({31'h0, irq}, 32'h00000000);
    rd(clock_select_pkg::OFF_IRQ_PEND, v);
    check(v, 32'h00000000);
    wr(clock_select_pkg::OFF_LOCK_KEY, 32'haa000000);
    wr(clock_select_pkg::OFF_CORE_GATE, 32'h00000000);
    wr(clock_select_pkg::OFF_MAIN_CTRL, 32'h00000002);
    check({29'h0, main_source}, 32'h00000000);
    check(gates.core, 32'h00010001);
    wr(clock_select_pkg::OFF_FAST_SEL, 32'h00000083);
    wr(clock_select_pkg::OFF_IRQ_ACK, 32'h80000000);
    wr(clock_select_pkg::OFF_IRQ_CLR_EN, 32'h80000000);
    $display("test lock done");

    wr(clock_select_pkg::OFF_IRQ_SET, 32'h00000020);
    pwr(clock_select_pkg::OFF_CPU_SEL, 32'h00000087);
    wait_ready();
    measure(p);
    check(32'(p), 32'h00000100);
    rd(clock_select_pkg::OFF_FAST_SEL, v);
    check(v, 32'h00000087);
    rd(clock_select_pkg::OFF_IRQ_PEND, v);
    check(v, 32'h00000020);
    check({31'h0, irq}, 32'h00000001);
    wr(clock_select_pkg::OFF_IRQ_ACK, 32'h00000020);
    check({31'h0, irq}, 32'h00000000);
    measure(p);
    pwr(clock_select_pkg::OFF_CPU_SEL, 32'h00000081);
    rd(clock_select_pkg::OFF_STATE, v);
    check({31'h0, v[5]}, 32'h00000000);
    wait_ready();
    measure(p);
    check(32'(p), 32'h00000004);
    check({31'h0, irq}, 32'h00000001);
    wr(clock_select_pkg::OFF_IRQ_CLR_EN, 32'h00000020);
    check({31'h0, irq}, 32'h00000000);
    rd(clock_select_pkg::OFF_IRQ_VIEW, v);
    check(v, 32'h00000000);
    wr(clock_select_pkg::OFF_IRQ_ACK, 32'h00000020);
    $display("test divide done");

    for (int s = 0; s < 4; s++) begin
      pwr(clock_select_pkg::OFF_MAIN_CTRL, 32'(s));
      check({29'h0, main_source}, 32'(s));
      rd(clock_select_pkg::OFF_MAIN_CTRL, v);
      check(v, 32'(s));
    end
    pwr(clock_select_pkg::OFF_PA_SEL, 32'h00000083);
    check({24'h0, pa_sel}, 32'h00000083);
    $display("test sources done");

    pwr(clock_select_pkg::OFF_CFD_CTRL, 32'h00000001);
    @(posedge sys_clk);
    clock_failure <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check({29'h0, main_source}, 32'h00000000);
    rd(clock_select_pkg::OFF_MAIN_CTRL, v);
    check(v, 32'h00000000);
    rd(clock_select_pkg::OFF_IRQ_PEND, v);
    check(v & 32'h00000001, 32'h00000001);
    clock_failure <= 1'b0;
    pwr(clock_select_pkg::OFF_CFD_CTRL, 32'h80000001);
    pwr(clock_select_pkg::OFF_CFD_CTRL, 32'h00000000);
    rd(clock_select_pkg::OFF_CFD_CTRL, v);
    check(v, 32'h80000001);
    $display("test failure done");

    pwr(clock_select_pkg::OFF_CPU_SEL, 32'h00000000);
    wait_ready();
    measure(p);
    check(32'(p), 32'h00000001);
    rd(clock_select_pkg::OFF_WAKE_SRC, v);
    check(v, 32'h00000300);
    $display("test undivide done");
    tally_and_finish();
  end
endmodule // testbench
